/* hw/bio_override.sv */
// binary input setpoint override, binary alarm outputs, failsafe and restart
// assumes contact pins are asynchronous; position and setpoint are on clk
`timescale 1ns/1ns
module bio_override
  import bio_pkg::*;
#(
  parameter int POS_W = BIO_POS_W,
  parameter int SEC_CYCLES = CYC_PER_SEC
) (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // contact inputs, high while the switch is open
  input wire logic [1:0] bin_in_raw,
  // parameter write port
  input wire logic cfg_wr,
  input wire logic [3:0] cfg_addr,
  input wire logic [15:0] cfg_wdata,
  // parameter read port, data one cycle after the index
  input wire logic [3:0] cfg_rd_addr,
  output logic [15:0] cfg_rdata,
  // setpoint path
  input wire logic [POS_W-1:0] setpoint_in,
  input wire logic [POS_W-1:0] position,
  input wire logic cascade_mode,
  input wire logic remote_sp_fault,
  output logic [POS_W-1:0] setpoint_out,
  // status
  output logic [7:0] input_state_flags,
  output logic input_asserted,
  output logic block_err_other,
  output logic failsafe_active,
  // binary output pins
  output logic [1:0] bin_out,
  // restart requests
  output logic warm_restart_req,
  output logic clear_trend_link
);

  typedef struct packed {
    logic [7:0] input_action_config;
    logic [7:0] output1_alarm_select;
    logic [7:0] output2_alarm_select;
    logic [POS_W-1:0] warn_upper_threshold;
    logic [POS_W-1:0] warn_lower_threshold;
    logic [POS_W-1:0] main_upper_threshold;
    logic [POS_W-1:0] main_lower_threshold;
    logic [15:0] failsafe_delay;
    logic [POS_W-1:0] failsafe_setpoint;
    logic [7:0] option_mask;
    bio_restart_e restart_sel;
    bio_fs_e fs_state;
    logic [31:0] tick_cnt;
    logic [15:0] sec_cnt;
    logic [POS_W-1:0] sp_out;
    logic [7:0] stat;
    logic diag;
    logic other_err;
    logic [1:0] pins;
    logic [15:0] rdata;
    logic warm_req;
    logic clr_tl;
    logic proc_pend;
  } bio_state_s;

  bio_state_s st_reg;
  bio_state_s st_next;

  logic [1:0] bin_in_sync;
  logic in_ok;
  logic out_ok;
  logic act1;
  logic act2;
  logic force1;
  logic force2;
  logic forced;
  logic hold_req;
  logic fault;
  logic [3:0] alarm_src;
  logic [1:0] pin_level;
  logic [7:0] sel_word [2];

  bio_sync2 #(.W(2)) u_sync (
    .clk(clk),
    .arst_n(arst_n),
    .d(bin_in_raw),
    .q(bin_in_sync)
  );

  // option gating of the input and output channels
  assign in_ok = st_reg.option_mask[OPT_BIN_IN_BIT]; // [RULE14]
  assign out_ok = st_reg.option_mask[OPT_BIN_OUT_BIT]; // [RULE14]
  assign act1 = in_ok & bin_in_sync[0];
  assign act2 = in_ok & bin_in_sync[1];
  assign force1 = act1 & st_reg.input_action_config[IAC_FORCE1_BIT];
  assign force2 = act2 & st_reg.input_action_config[IAC_FORCE2_BIT];
  assign forced = force1 | force2;
  assign hold_req = force1 & force2; // [RULE3]
  assign fault = cascade_mode & remote_sp_fault;

  // alarm comparisons shared by both outputs
  assign alarm_src[OAS_WARN_HI_BIT] = position > st_reg.warn_upper_threshold; // [RULE8]
  assign alarm_src[OAS_WARN_LO_BIT] = position < st_reg.warn_lower_threshold; // [RULE9]
  assign alarm_src[OAS_MAIN_HI_BIT] = position > st_reg.main_upper_threshold; // [RULE10]
  assign alarm_src[OAS_MAIN_LO_BIT] = position < st_reg.main_lower_threshold; // [RULE11]

  assign sel_word[0] = st_reg.output1_alarm_select;
  assign sel_word[1] = st_reg.output2_alarm_select;

  // one select word per output channel
  for (genvar g = 0; g < 2; g++) begin : g_out
    logic alarm;
    assign alarm = |(sel_word[g][3:0] & alarm_src); // [RULE13]
    assign pin_level[g] = out_ok & (alarm ^ sel_word[g][OAS_INVERT_BIT]); // [RULE12]
  end

  always_comb begin
    st_next = st_reg;
    st_next.warm_req = 1'b0;
    st_next.clr_tl = 1'b0;
    st_next.proc_pend = 1'b0;

    // parameter writes
    if (cfg_wr) begin
      case (cfg_addr)
        IDX_INPUT_ACTION: st_next.input_action_config = cfg_wdata[7:0];
        IDX_OUT1_SELECT: st_next.output1_alarm_select = cfg_wdata[7:0];
        IDX_OUT2_SELECT: st_next.output2_alarm_select = cfg_wdata[7:0];
        IDX_WARN_UPPER: st_next.warn_upper_threshold = cfg_wdata[POS_W-1:0];
        IDX_WARN_LOWER: st_next.warn_lower_threshold = cfg_wdata[POS_W-1:0];
        IDX_MAIN_UPPER: st_next.main_upper_threshold = cfg_wdata[POS_W-1:0];
        IDX_MAIN_LOWER: st_next.main_lower_threshold = cfg_wdata[POS_W-1:0];
        IDX_FS_DELAY: st_next.failsafe_delay = cfg_wdata;
        IDX_FS_SETPOINT: st_next.failsafe_setpoint = cfg_wdata[POS_W-1:0];
        IDX_OPTION_MASK: st_next.option_mask = cfg_wdata[7:0]; // [RULE14]
        IDX_RESTART: st_next.restart_sel = bio_restart_e'(cfg_wdata[2:0]);
        default: begin
        end
      endcase
    end

    // restart selector execution
    case (st_reg.restart_sel)
      RST_RESOURCE: begin
        st_next.restart_sel = RST_RUN; // [RULE17] [RULE20]
      end
      RST_PROCESSOR: begin
        st_next.warm_req = 1'b1; // [RULE18]
        st_next.restart_sel = RST_RUN; // [RULE20]
      end
      RST_DEFAULTS: begin
        // option mask counts as system data and survives
        st_next.input_action_config = IAC_RST; // [RULE19]
        st_next.output1_alarm_select = OAS_RST;
        st_next.output2_alarm_select = OAS_RST;
        st_next.warn_upper_threshold = WARN_UPPER_RST[POS_W-1:0];
        st_next.warn_lower_threshold = WARN_LOWER_RST[POS_W-1:0];
        st_next.main_upper_threshold = MAIN_UPPER_RST[POS_W-1:0];
        st_next.main_lower_threshold = MAIN_LOWER_RST[POS_W-1:0];
        st_next.failsafe_delay = FS_DELAY_RST;
        st_next.failsafe_setpoint = FS_SETPOINT_RST[POS_W-1:0];
        st_next.clr_tl = 1'b1; // [RULE19]
        st_next.proc_pend = 1'b1;
        st_next.restart_sel = RST_RUN; // [RULE20]
      end
      default: begin
      end
    endcase
    if (st_reg.proc_pend) begin
      st_next.warm_req = 1'b1; // [RULE19]
    end

    // failsafe delay in whole seconds
    case (st_reg.fs_state)
      FS_IDLE: begin
        st_next.tick_cnt = '0;
        st_next.sec_cnt = '0;
        if (fault) begin
          st_next.fs_state = (st_reg.failsafe_delay == 16'h0000) ? FS_ACTIVE : FS_WAIT;
        end
      end
      FS_WAIT: begin
        if (!fault) begin
          st_next.fs_state = FS_IDLE;
        end else if (st_reg.tick_cnt == 32'(SEC_CYCLES - 1)) begin
          st_next.tick_cnt = '0;
          st_next.sec_cnt = st_reg.sec_cnt + 16'h0001;
          if (st_reg.sec_cnt + 16'h0001 >= st_reg.failsafe_delay) begin
            st_next.fs_state = FS_ACTIVE; // [RULE15]
          end
        end else begin
          st_next.tick_cnt = st_reg.tick_cnt + 32'h0000_0001;
        end
      end
      FS_ACTIVE: begin
        if (!fault) begin
          st_next.fs_state = FS_IDLE;
        end
      end
      default: st_next.fs_state = FS_IDLE;
    endcase

    // setpoint selection, contact forcing first
    if (hold_req) begin
      st_next.sp_out = st_reg.sp_out; // [RULE3]
    end else if (force1) begin
      st_next.sp_out = SP_ZERO[POS_W-1:0]; // [RULE1]
    end else if (force2) begin
      st_next.sp_out = SP_FULL[POS_W-1:0]; // [RULE2]
    end else if (st_reg.fs_state == FS_ACTIVE) begin
      st_next.sp_out = st_reg.failsafe_setpoint; // [RULE16]
    end else begin
      st_next.sp_out = setpoint_in;
    end

    // status and diagnostics
    st_next.stat = 8'h00;
    st_next.stat[STAT_ACT1_BIT] = act1; // [RULE5]
    st_next.stat[STAT_ACT2_BIT] = act2; // [RULE5]
    st_next.stat[STAT_FORCED_BIT] = forced; // [RULE6] [RULE7]
    st_next.diag = (act1 & st_reg.input_action_config[IAC_DIAG1_BIT]) |
                   (act2 & st_reg.input_action_config[IAC_DIAG2_BIT]); // [RULE4]
    st_next.other_err = act1 | act2; // [RULE21]
    st_next.pins = pin_level;

    // read data
    case (cfg_rd_addr)
      IDX_INPUT_ACTION: st_next.rdata = {8'h00, st_reg.input_action_config};
      IDX_INPUT_STATE: st_next.rdata = {8'h00, st_reg.stat};
      IDX_OUT1_SELECT: st_next.rdata = {8'h00, st_reg.output1_alarm_select};
      IDX_OUT2_SELECT: st_next.rdata = {8'h00, st_reg.output2_alarm_select};
      IDX_WARN_UPPER: st_next.rdata = 16'(st_reg.warn_upper_threshold);
      IDX_WARN_LOWER: st_next.rdata = 16'(st_reg.warn_lower_threshold);
      IDX_MAIN_UPPER: st_next.rdata = 16'(st_reg.main_upper_threshold);
      IDX_MAIN_LOWER: st_next.rdata = 16'(st_reg.main_lower_threshold);
      IDX_FS_DELAY: st_next.rdata = st_reg.failsafe_delay;
      IDX_FS_SETPOINT: st_next.rdata = 16'(st_reg.failsafe_setpoint);
      IDX_OPTION_MASK: st_next.rdata = {8'h00, st_reg.option_mask};
      IDX_RESTART: st_next.rdata = {13'h0000, st_reg.restart_sel};
      default: st_next.rdata = 16'h0000;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_reg.input_action_config <= IAC_RST;
      st_reg.output1_alarm_select <= OAS_RST;
      st_reg.output2_alarm_select <= OAS_RST;
      st_reg.warn_upper_threshold <= WARN_UPPER_RST[POS_W-1:0];
      st_reg.warn_lower_threshold <= WARN_LOWER_RST[POS_W-1:0];
      st_reg.main_upper_threshold <= MAIN_UPPER_RST[POS_W-1:0];
      st_reg.main_lower_threshold <= MAIN_LOWER_RST[POS_W-1:0];
      st_reg.failsafe_delay <= FS_DELAY_RST;
      st_reg.failsafe_setpoint <= FS_SETPOINT_RST[POS_W-1:0];
      st_reg.option_mask <= OPT_MASK_RST;
      st_reg.restart_sel <= RST_RUN;
      st_reg.fs_state <= FS_IDLE;
      st_reg.tick_cnt <= '0;
      st_reg.sec_cnt <= '0;
      st_reg.sp_out <= '0;
      st_reg.stat <= '0;
      st_reg.diag <= 1'b0;
      st_reg.other_err <= 1'b0;
      st_reg.pins <= '0;
      st_reg.rdata <= '0;
      st_reg.warm_req <= 1'b0;
      st_reg.clr_tl <= 1'b0;
      st_reg.proc_pend <= 1'b0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign cfg_rdata = st_reg.rdata;
  assign setpoint_out = st_reg.sp_out;
  assign input_state_flags = st_reg.stat;
  assign input_asserted = st_reg.diag;
  assign block_err_other = st_reg.other_err;
  assign failsafe_active = (st_reg.fs_state == FS_ACTIVE);
  assign bin_out = st_reg.pins;
  assign warm_restart_req = st_reg.warm_req;
  assign clear_trend_link = st_reg.clr_tl;

  // checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);

  sequence defaults_steps;
    clear_trend_link && !warm_restart_req ##1 warm_restart_req;
  endsequence

  sequence fs_ready;
    fault && st_reg.fs_state == FS_ACTIVE && !forced;
  endsequence

  force_zero_a: assert property ( // [RULE1]
    force1 && !force2 |=> setpoint_out == SP_ZERO[POS_W-1:0])
    else $error("channel 1 forcing did not drive 0 percent");

  force_full_a: assert property ( // [RULE2]
    force2 && !force1 |=> setpoint_out == SP_FULL[POS_W-1:0])
    else $error("channel 2 forcing did not drive 100 percent");

  hold_last_a: assert property ( // [RULE3]
    hold_req |=> $stable(setpoint_out))
    else $error("setpoint moved while both inputs hold it");

  diag_flag_a: assert property ( // [RULE4]
    act1 && st_reg.input_action_config[IAC_DIAG1_BIT] |=> input_asserted)
    else $error("input-asserted flag missing for channel 1");

  forced_code_a: assert property ( // [RULE7]
    forced |=> input_state_flags == {1'b1, 5'h00, $past(act2), $past(act1)})
    else $error("forced input status code wrong");

  warn_high_a: assert property ( // [RULE8]
    out_ok && alarm_src[OAS_WARN_HI_BIT] && st_reg.output1_alarm_select[OAS_WARN_HI_BIT]
    |=> bin_out[0] == !$past(st_reg.output1_alarm_select[OAS_INVERT_BIT]))
    else $error("output 1 not active on warning high alarm");

  idle_pin_a: assert property ( // [RULE12]
    out_ok && (st_reg.output2_alarm_select[3:0] & alarm_src) == 4'h0
    |=> bin_out[1] == $past(st_reg.output2_alarm_select[OAS_INVERT_BIT]))
    else $error("output 2 idle level does not follow polarity");

  fs_wait_a: assert property ( // [RULE15]
    st_reg.fs_state == FS_WAIT |-> st_reg.sec_cnt < st_reg.failsafe_delay)
    else $error("failsafe waited past its delay");

  fs_value_a: assert property ( // [RULE16]
    fs_ready |=> setpoint_out == $past(st_reg.failsafe_setpoint))
    else $error("failsafe setpoint not applied");

  resource_a: assert property ( // [RULE17]
    st_reg.restart_sel == RST_RESOURCE |=> !warm_restart_req && !clear_trend_link)
    else $error("resource restart had an effect");

  defaults_a: assert property ( // [RULE19]
    st_reg.restart_sel == RST_DEFAULTS |=> defaults_steps)
    else $error("defaults restart sequence wrong");

  back_to_run_a: assert property ( // [RULE20]
    st_reg.restart_sel inside {RST_RESOURCE, RST_PROCESSOR, RST_DEFAULTS} && !cfg_wr
    |=> st_reg.restart_sel == RST_RUN)
    else $error("restart selector did not return to run");

endmodule

/* hw/bio_pkg.sv */
// constants, types and register indices for the binary i/o setpoint override
// assumes a single 10 MHz clock and a simple parameter write/read port
// Summary of operation
// (RULE1) input 1 active forces setpoint to 0%
// (RULE2) input 2 active forces setpoint to 100%
// (RULE3) both enabled and both open: hold setpoint
// (RULE4) diag enable bits raise input-asserted flag
// (RULE5) status bits 0,1 show active input channels
// (RULE6) status bit 7 shows setpoint being forced
// (RULE7) forced status reads 129, 130 or 131
// (RULE8) output bit 0: above warning high threshold
// (RULE9) output bit 1: below warning low threshold
// (RULE10) output bit 2: above main high threshold
// (RULE11) output bit 3: below main low threshold
// (RULE12) output bit 7 selects active-low drive
// (RULE13) each output has its own select word
// (RULE14) options work only when mask bit set
// (RULE15) cascade fault held for delay: take failsafe
// (RULE16) failsafe applies preset failsafe setpoint
// (RULE17) resource restart changes nothing
// (RULE18) processor restart requests a warm restart
// (RULE19) defaults restart reinits config, clears, restarts
// (RULE20) restart selector returns to run afterwards
// (RULE21) active input reports generic other error
// (RULE22) inputs pass two flip-flops before use
package bio_pkg;

  localparam int BIO_POS_W = 16;

  // setpoint and position scale: 0.01 % per count
  localparam logic [15:0] SP_ZERO = 16'h0000;
  localparam logic [15:0] SP_FULL = 16'h2710;

  // timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int SECOND_NS = 1000000000;
  localparam int CYC_PER_SEC = SECOND_NS / CLK_PERIOD_NS;

  // register indices on the parameter port
  localparam logic [3:0] IDX_INPUT_ACTION = 4'h0;
  localparam logic [3:0] IDX_INPUT_STATE = 4'h1;
  localparam logic [3:0] IDX_OUT1_SELECT = 4'h2;
  localparam logic [3:0] IDX_OUT2_SELECT = 4'h3;
  localparam logic [3:0] IDX_WARN_UPPER = 4'h4;
  localparam logic [3:0] IDX_WARN_LOWER = 4'h5;
  localparam logic [3:0] IDX_MAIN_UPPER = 4'h6;
  localparam logic [3:0] IDX_MAIN_LOWER = 4'h7;
  localparam logic [3:0] IDX_FS_DELAY = 4'h8;
  localparam logic [3:0] IDX_FS_SETPOINT = 4'h9;
  localparam logic [3:0] IDX_OPTION_MASK = 4'hA;
  localparam logic [3:0] IDX_RESTART = 4'hB;

  // input_action_config fields
  localparam int IAC_FORCE1_BIT = 0;
  localparam int IAC_FORCE2_BIT = 1;
  localparam int IAC_DIAG1_BIT = 2;
  localparam int IAC_DIAG2_BIT = 3;

  // input_state_flags fields
  localparam int STAT_ACT1_BIT = 0;
  localparam int STAT_ACT2_BIT = 1;
  localparam int STAT_FORCED_BIT = 7;

  // output alarm select fields
  localparam int OAS_WARN_HI_BIT = 0;
  localparam int OAS_WARN_LO_BIT = 1;
  localparam int OAS_MAIN_HI_BIT = 2;
  localparam int OAS_MAIN_LO_BIT = 3;
  localparam int OAS_INVERT_BIT = 7;

  // installed-option mask fields
  localparam int OPT_BIN_IN_BIT = 0;
  localparam int OPT_BIN_OUT_BIT = 1;

  // reset values
  localparam logic [7:0] IAC_RST = 8'h00;
  localparam logic [7:0] OAS_RST = 8'h00;
  localparam logic [15:0] WARN_UPPER_RST = 16'h2710;
  localparam logic [15:0] WARN_LOWER_RST = 16'h0000;
  localparam logic [15:0] MAIN_UPPER_RST = 16'h2710;
  localparam logic [15:0] MAIN_LOWER_RST = 16'h0000;
  localparam logic [15:0] FS_DELAY_RST = 16'h0000;
  localparam logic [15:0] FS_SETPOINT_RST = 16'h0000;
  localparam logic [7:0] OPT_MASK_RST = 8'h03;

  typedef enum logic [2:0] {
    RST_UNINIT = 3'h1,
    RST_RUN = 3'h2,
    RST_RESOURCE = 3'h3,
    RST_DEFAULTS = 3'h4,
    RST_PROCESSOR = 3'h5
  } bio_restart_e;

  typedef enum logic [1:0] {
    FS_IDLE = 2'h0,
    FS_WAIT = 2'h1,
    FS_ACTIVE = 2'h2
  } bio_fs_e;

endpackage

/* hw/bio_sync2.sv */
// two-stage synchroniser for asynchronous level inputs
// assumes the inputs are quasi-static contact levels
`timescale 1ns/1ns
module bio_sync2 #(
  parameter int W = 2
) (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // levels
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } bio_sync_s;

  bio_sync_s st_reg;
  bio_sync_s st_next;

  always_comb begin
    st_next.s1 = d;
    st_next.s2 = st_reg.s1; // [RULE22]
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign q = st_reg.s2;

  sync_delay_a: assert property (@(posedge clk) disable iff (!arst_n) // [RULE22]
    ##2 (q == $past(d, 2)))
    else $error("synchroniser output does not follow input after two edges");

endmodule

/* tb/bio_contacts.sv */
// far side of the override block: two contact switches and two alarm loads
// assumes open_cmd is set by the bench; contacts bounce briefly on each change
`timescale 1ns/1ns
module bio_contacts (
  // commanded switch states, high = open
  input wire logic [1:0] open_cmd,
  // alarm pin levels from the block
  input wire logic [1:0] bin_out,
  // contact levels seen by the block
  output logic [1:0] bin_in_raw,
  // load state, high while energised
  output logic [1:0] load_on
);
  logic [1:0] chg;

  assign load_on = bin_out;

  // contacts change off the clock and bounce before settling
  initial begin
    bin_in_raw = 2'b00;
    forever begin
      @(open_cmd);
      chg = bin_in_raw ^ open_cmd;
      #13 bin_in_raw = open_cmd;
      #6 bin_in_raw = open_cmd ^ chg;
      #6 bin_in_raw = open_cmd;
    end
  end
endmodule

/* tb/tb.sv */
// self-checking bench for the binary i/o setpoint override block
// assumes bio_pkg, bio_override and the contact model bio_contacts
`timescale 1ns/1ns
module tb;
  import bio_pkg::*;
  localparam int SEC = 10;
  logic clk, arst_n, cfg_wr, cascade_mode, remote_sp_fault;
  logic [3:0] cfg_addr, cfg_rd_addr;
  logic [15:0] cfg_wdata, cfg_rdata, setpoint_in, position, setpoint_out, r, a, b;
  logic [15:0] wu, wl, mu, ml, p;
  logic [7:0] input_state_flags, c, s1, s2, m;
  logic input_asserted, block_err_other, failsafe_active, warm_restart_req, clear_trend_link;
  logic [1:0] bin_out, bin_in_raw, open_cmd, load_on, o, f;
  int err_count, samples_checked, n, cyc, n_warm, n_clr, t_warm, t_clr;
  integer seed = 83249;

  bio_override #(.POS_W(16), .SEC_CYCLES(SEC)) bio_override_inst (.clk(clk), .arst_n(arst_n),
    .bin_in_raw(bin_in_raw), .cfg_wr(cfg_wr), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata),
    .cfg_rd_addr(cfg_rd_addr), .cfg_rdata(cfg_rdata), .setpoint_in(setpoint_in),
    .position(position), .cascade_mode(cascade_mode), .remote_sp_fault(remote_sp_fault),
    .setpoint_out(setpoint_out), .input_state_flags(input_state_flags),
    .input_asserted(input_asserted), .block_err_other(block_err_other),
    .failsafe_active(failsafe_active), .bin_out(bin_out), .warm_restart_req(warm_restart_req),
    .clear_trend_link(clear_trend_link));
  bio_contacts bio_contacts_inst (.open_cmd(open_cmd), .bin_out(bin_out),
    .bin_in_raw(bin_in_raw), .load_on(load_on));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // restart pulse monitor, sampled mid-cycle
  always @(negedge clk) begin
    cyc++;
    if (warm_restart_req === 1'b1) begin
      n_warm++;
      t_warm = cyc;
    end
    if (clear_trend_link === 1'b1) begin
      n_clr++;
      t_clr = cyc;
    end
  end

  task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
    samples_checked++;
    if (g !== e) begin
      err_count++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic cyc_n(int k);
    repeat (k) @(negedge clk);
  endtask

  task automatic wr(logic [3:0] ad, logic [15:0] d);
    cfg_addr = ad;
    cfg_wdata = d;
    cfg_wr = 1'b1;
    @(negedge clk);
    cfg_wr = 1'b0;
    @(negedge clk);
  endtask

  task automatic rd(logic [3:0] ad, output logic [15:0] d);
    cfg_rd_addr = ad;
    @(negedge clk);
    d = cfg_rdata;
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  function automatic logic [15:0] rnd_pos();
    return 16'($unsigned($random(seed)) % 10001);
  endfunction

  function automatic logic [15:0] reg_rst(int ad);
    case (ad)
      4: return WARN_UPPER_RST;
      5: return WARN_LOWER_RST;
      6: return MAIN_UPPER_RST;
      7: return MAIN_LOWER_RST;
      8: return FS_DELAY_RST;
      9: return FS_SETPOINT_RST;
      10: return {8'h00, OPT_MASK_RST};
      11: return {13'h0000, RST_RUN};
      default: return 16'h0000;
    endcase
  endfunction

  function automatic logic [15:0] exp_sp(logic [1:0] fe, logic [1:0] op, logic [15:0] held,
                                         logic [15:0] sp);
    logic [1:0] act;
    act = fe & op;
    if (act == 2'b11) return held;
    if (act[0]) return SP_ZERO;
    if (act[1]) return SP_FULL;
    return sp;
  endfunction

  function automatic logic alm(logic [7:0] s, logic [7:0] mk);
    logic hit;
    hit = (s[0] && p > wu) || (s[1] && p < wl) || (s[2] && p > mu) || (s[3] && p < ml);
    return mk[1] & (hit ^ s[7]);
  endfunction

  initial begin
    #(100 * 6000);
    err_count++;
    final_report();
  end

  initial begin
    arst_n = 1'b0;
    cfg_wr = 1'b0;
    cfg_addr = 4'h0;
    cfg_wdata = 16'h0000;
    cfg_rd_addr = 4'h0;
    setpoint_in = 16'h1388;
    position = 16'h1388;
    cascade_mode = 1'b0;
    remote_sp_fault = 1'b0;
    open_cmd = 2'b00;
    repeat (5) @(negedge clk);
    chk("setpoint_out in reset", 16'h0000, setpoint_out);
    arst_n = 1'b1;
    // reset values, read-only status and unmapped places
    wr(IDX_INPUT_STATE, 16'hFFFF);
    wr(4'hC, 16'hFFFF);
    for (int i = 0; i < 16; i++) begin
      rd(4'(i), r);
      chk("register reset", reg_rst(i), r);
    end
    // contact forcing, status and diagnostics over every force enable and every nonzero input combination
    for (int i = 0; i < 12; i++) begin
      f = 2'(i / 3);
      o = 2'(i % 3 + 1);
      c = (8'($random(seed)) & 8'h0C) | {6'h00, f};
      wr(IDX_INPUT_ACTION, {8'h00, c});
      a = rnd_pos();
      b = rnd_pos();
      setpoint_in = a;
      cyc_n(2);
      open_cmd = o;
      cyc_n(4);
      setpoint_in = b;
      cyc_n(2);
      chk("setpoint_out", exp_sp(f, o, a, b), setpoint_out);
      chk("flags", {8'h00, |(f & o), 5'h00, o}, input_state_flags);
      chk("input_asserted", (c[2] & o[0]) | (c[3] & o[1]), input_asserted);
      chk("block_err_other", |o, block_err_other);
      rd(IDX_INPUT_STATE, r);
      chk("status read", {8'h00, |(f & o), 5'h00, o}, r);
      open_cmd = 2'b00;
      cyc_n(4);
    end
    // input option not installed
    wr(IDX_OPTION_MASK, 16'h0002);
    wr(IDX_INPUT_ACTION, 16'h000D);
    open_cmd = 2'b01;
    cyc_n(4);
    chk("flags, option off", 16'h0000, input_state_flags);
    chk("setpoint, option off", setpoint_in, setpoint_out);
    chk("other, option off", 16'h0000, block_err_other);
    chk("diag, option off", 16'h0000, input_asserted);
    open_cmd = 2'b00;
    wr(IDX_INPUT_ACTION, 16'h0000);
    // alarm outputs with random thresholds and equality corners
    for (int i = 0; i < 24; i++) begin
      wu = rnd_pos();
      wl = rnd_pos();
      mu = rnd_pos();
      ml = rnd_pos();
      case (i % 5)
        0: p = wu;
        1: p = wl;
        2: p = mu;
        3: p = ml;
        default: p = rnd_pos();
      endcase
      s1 = 8'($random(seed)) & 8'h8F;
      s2 = 8'($random(seed)) & 8'h8F;
      m = (i % 6 == 5) ? 8'h01 : 8'h03;
      wr(IDX_WARN_UPPER, wu);
      wr(IDX_WARN_LOWER, wl);
      wr(IDX_MAIN_UPPER, mu);
      wr(IDX_MAIN_LOWER, ml);
      wr(IDX_OUT1_SELECT, {8'h00, s1});
      wr(IDX_OUT2_SELECT, {8'h00, s2});
      wr(IDX_OPTION_MASK, {8'h00, m});
      position = p;
      cyc_n(3);
      chk("load_on 1", alm(s1, m), load_on[0]);
      chk("load_on 2", alm(s2, m), load_on[1]);
    end
    wr(IDX_OPTION_MASK, 16'h0003);
    // failsafe after a persisting remote setpoint fault
    for (int d = 0; d < 3; d += 2) begin
      a = rnd_pos();
      wr(IDX_FS_DELAY, 16'(d));
      wr(IDX_FS_SETPOINT, a);
      remote_sp_fault = 1'b1;
      cyc_n(30);
      chk("failsafe outside cascade", 16'h0000, failsafe_active);
      cascade_mode = 1'b1;
      n = 0;
      while (failsafe_active !== 1'b1 && n < 100) begin
        @(negedge clk);
        n++;
      end
      chk("failsafe delay", 16'h0001, (n >= d * SEC + 1 && n <= d * SEC + 2));
      cyc_n(2);
      chk("failsafe setpoint", a, setpoint_out);
      remote_sp_fault = 1'b0;
      cyc_n(3);
      chk("failsafe released", 16'h0000, failsafe_active);
      chk("setpoint released", setpoint_in, setpoint_out);
      cascade_mode = 1'b0;
    end
    // restart selector
    wr(IDX_RESTART, {13'h0000, RST_RESOURCE});
    cyc_n(3);
    rd(IDX_RESTART, r);
    chk("restart selector", {13'h0000, RST_RUN}, r);
    chk("resource pulses", 16'h0000, 16'(n_warm + n_clr));
    wr(IDX_RESTART, {13'h0000, RST_PROCESSOR});
    cyc_n(4);
    chk("processor warm", 16'h0001, 16'(n_warm));
    chk("processor clear", 16'h0000, 16'(n_clr));
    wr(IDX_INPUT_ACTION, 16'h00A5);
    wr(IDX_OUT1_SELECT, 16'h008C);
    wr(IDX_OUT2_SELECT, 16'h0003);
    wr(IDX_OPTION_MASK, 16'h0001);
    rd(IDX_INPUT_ACTION, r);
    chk("input_action_config", 16'h00A5, r);
    rd(IDX_OUT1_SELECT, r);
    chk("output1_alarm_select", 16'h008C, r);
    rd(IDX_OUT2_SELECT, r);
    chk("output2_alarm_select", 16'h0003, r);
    wr(IDX_RESTART, {13'h0000, RST_DEFAULTS});
    cyc_n(5);
    chk("defaults clear", 16'h0001, 16'(n_clr));
    chk("defaults warm", 16'h0002, 16'(n_warm));
    chk("clear before warm", 16'h0001, 16'(t_warm - t_clr));
    for (int i = 0; i < 4; i++) begin
      if (i != 1) begin
        rd(4'(i), r);
        chk("config after defaults", 16'h0000, r);
      end
    end
    rd(IDX_OPTION_MASK, r);
    chk("option mask kept", 16'h0001, r);
    for (int i = 4; i < 10; i++) begin
      rd(4'(i), r);
      chk("values after defaults", reg_rst(i), r);
    end
    rd(IDX_RESTART, r);
    chk("selector after defaults", {13'h0000, RST_RUN}, r);
    final_report();
  end
endmodule
